// *** mbcfg_pkg.sv ***
// mbcfg_pkg: register indices, field layouts, reset values and timing counts
// for the fieldbus configuration and link watchdog bank.
// assumes a single 250 MHz system clock.
package mbcfg_pkg;
  localparam int unsigned CLOCK_HZ       = 250_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned CYCLES_PER_MS  = CLOCK_HZ / MS_PER_S;

  // register indices (16-bit registers, holding-register space)
  localparam logic [7:0] REG_IDENT          = 8'h00;
  localparam logic [7:0] REG_SWITCHES       = 8'h01;
  localparam logic [7:0] REG_BAUD           = 8'h02;
  localparam logic [7:0] REG_FRAME          = 8'h03;
  localparam logic [7:0] REG_PARITY         = 8'h04;
  localparam logic [7:0] REG_REPLY_DELAY    = 8'h05;
  localparam logic [7:0] REG_PROTOCOL       = 8'h06;
  localparam logic [7:0] REG_WATCHDOG       = 8'h08;
  localparam logic [7:0] REG_DEFAULT_OUT    = 8'h0C;
  localparam logic [7:0] REG_STATION_ADDR   = 8'h0D;

  // reset / factory values
  localparam logic [15:0] BAUD_DEFAULT      = 16'h0003;
  localparam logic [15:0] FRAME_DEFAULT     = 16'h0801;
  localparam logic [15:0] PARITY_DEFAULT    = 16'h0000;
  localparam logic [15:0] DELAY_DEFAULT     = 16'h0000;
  localparam logic [15:0] PROTOCOL_DEFAULT  = 16'h0000;
  localparam logic [15:0] WATCHDOG_DEFAULT  = 16'h0000;
  localparam logic [15:0] DEFOUT_DEFAULT    = 16'h0000;
  localparam logic [15:0] IDENT_VALUE       = 16'h0A5A; // arbitrary value

  // frame-format layout: stop bits in low byte, data bits in high byte
  localparam int unsigned FRAME_STOP_LSB    = 0;
  localparam int unsigned FRAME_DATA_LSB    = 8;
  localparam logic [7:0]  STOP_TWO          = 8'h02;
  localparam logic [7:0]  DATA_SEVEN        = 8'h07;

  // baud codes and decoded rates
  localparam logic [15:0] BAUD_CODE_MAX     = 16'h0006;
  localparam logic [19:0] BAUD_RATE_2400    = 20'h00960;
  localparam logic [19:0] BAUD_RATE_4800    = 20'h012C0;
  localparam logic [19:0] BAUD_RATE_9600    = 20'h02580;
  localparam logic [19:0] BAUD_RATE_19200   = 20'h04B00;
  localparam logic [19:0] BAUD_RATE_38400   = 20'h09600;
  localparam logic [19:0] BAUD_RATE_57600   = 20'h0E100;
  localparam logic [19:0] BAUD_RATE_115200  = 20'h1C200;
  localparam logic [3:0]  BAUD_OTHER_SCALE  = 4'hA;

  typedef enum logic [2:0] {
    MBCFG_PAR_NONE,
    MBCFG_PAR_ODD,
    MBCFG_PAR_EVEN,
    MBCFG_PAR_ZERO,
    MBCFG_PAR_ONE
  } mbcfg_parity_t;

  typedef enum logic [1:0] {
    MBCFG_LINK_IDLE,
    MBCFG_LINK_DELAY,
    MBCFG_LINK_SEND
  } mbcfg_link_t;
endpackage

// *** mbcfg_ms_tick.sv ***
// mbcfg_ms_tick: divider giving a one-cycle pulse every millisecond.
// assumes clock_in runs at the rate CYCLES_PER_MS was derived from.
`timescale 1ns/100ps
`default_nettype none
module mbcfg_ms_tick #(
  parameter int unsigned DIVIDE = mbcfg_pkg::CYCLES_PER_MS
) (
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic restart_in,
  output logic      tick_out
);
  import mbcfg_pkg::*;

  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } mbcfg_tick_state_t;

  mbcfg_tick_state_t state;
  mbcfg_tick_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (restart_in) begin
      next_state.count = '0;
    end else if (state.count == DIVIDE - 1) begin
      next_state.count = '0;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 32'h1;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick_out = state.tick;
endmodule
`default_nettype wire

// *** mbcfg_bank.sv ***
// mbcfg_bank: communication configuration registers, station address,
// reply hold-off and link watchdog of a serial fieldbus i/o module.
// assumes a frame engine outside that decodes requests into register
// accesses and valid-frame pulses, and serialises replies on request.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - baud codes 0..6 decode to 2400,4800,9600,19200,38400,57600,115200 bit/s.
// - any other baud value gives a line rate of value times ten.
// - parity 0 none, 1 odd, 2 even, 3 forced zero, 4 forced one.
// - frame format selects one or two stop bits.
// - frame format selects seven or eight data bits.
// - each reply waits the reply-delay milliseconds before transmission starts.
// - protocol variant 0 selects binary framing, 1 selects ascii framing.
// - factory defaults 19200 baud, no parity, 8 data, 1 stop, no delay, binary.
// - restore switch closed at power-up loads factory communication defaults.
// - a restore also clears every other held register value.
// - station address is sum of five weighted switches, giving 0 to 31.
// - addresses 32 to 255 only come from a bus or port write.
// - output bits at 00001 (codes 1,5,15), input bits 10001 (code 2).
// - registers at 30001 and 40001 are sixteen bits wide.
// - watchdog register holds a sixteen-bit millisecond timeout.
// - no valid message before timeout forces outputs to their default states.
// - watchdog resets to zero, and zero disables it entirely.
// - default output pattern comes from the default-output register.
// - link indicator lights while answering a correct frame to us.
module mbcfg_bank #(
  parameter int unsigned OUT_WIDTH     = 8,
  parameter int unsigned MS_DIVIDE     = mbcfg_pkg::CYCLES_PER_MS
) (
  input  wire logic                  clock_in,
  input  wire logic                  reset_in,
  input  wire logic                  address_switch_weight_1_in,
  input  wire logic                  address_switch_weight_2_in,
  input  wire logic                  address_switch_weight_4_in,
  input  wire logic                  address_switch_weight_8_in,
  input  wire logic                  address_switch_weight_16_in,
  input  wire logic                  restore_defaults_switch_in,
  input  wire logic                  reg_write_in,
  input  wire logic                  reg_read_in,
  input  wire logic [7:0]            reg_index_in,
  input  wire logic [15:0]           reg_wdata_in,
  input  wire logic                  frame_valid_own_in,
  input  wire logic                  reply_done_in,
  input  wire logic [OUT_WIDTH-1:0]  output_request_in,
  output logic      [15:0]           reg_rdata_out,
  output logic                       reg_error_out,
  output logic      [19:0]           line_rate_out,
  output mbcfg_pkg::mbcfg_parity_t   parity_mode_out,
  output logic                       two_stop_bits_out,
  output logic                       seven_data_bits_out,
  output logic                       ascii_framing_out,
  output logic      [7:0]            station_address_out,
  output logic                       reply_start_out,
  output logic                       link_indicator_out,
  output logic      [OUT_WIDTH-1:0]  relay_outputs_out,
  output logic                       watchdog_expired_out,
  output logic                       clear_all_registers_out
);
  import mbcfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0]          baud;
    logic [15:0]          frame;
    logic [15:0]          parity;
    logic [15:0]          delay;
    logic [15:0]          protocol;
    logic [15:0]          watchdog;
    logic [15:0]          default_out;
    logic [7:0]           bus_address;
    logic                 bus_address_set;
    logic                 restore_seen;
    logic                 strap_done;
    mbcfg_link_t          link;
    logic [15:0]          delay_left;
    logic [15:0]          wd_elapsed;
    logic                 expired;
    logic                 settings_dirty;
    logic [15:0]          rdata;
    logic                 rerror;
    logic [19:0]          line_rate;
    mbcfg_parity_t        parity_mode;
    logic                 two_stop;
    logic                 seven_data;
    logic                 ascii;
    logic [7:0]           station;
    logic                 reply_start;
    logic                 link_led;
    logic [OUT_WIDTH-1:0] relays;
    logic                 clear_all;
  } mbcfg_state_t;

  mbcfg_state_t state;
  mbcfg_state_t next_state;
  logic         ms_tick;
  logic         wd_restart;
  logic [4:0]   switch_address;
  logic [19:0]  decoded_rate;
  mbcfg_parity_t decoded_parity;

  ////////////////////////////////////////////////////////////////////////////
  // one divider serves both the reply hold-off and the watchdog
  mbcfg_ms_tick #(
    .DIVIDE (MS_DIVIDE)
  ) u_ms_tick (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .restart_in (wd_restart),
    .tick_out   (ms_tick)
  );

  assign switch_address = {address_switch_weight_16_in, address_switch_weight_8_in,
                           address_switch_weight_4_in, address_switch_weight_2_in,
                           address_switch_weight_1_in};

  assign wd_restart = frame_valid_own_in
                    || (reg_write_in && reg_index_in == REG_WATCHDOG);

  always_comb begin
    case (state.baud)
      16'h0000: decoded_rate = BAUD_RATE_2400;
      16'h0001: decoded_rate = BAUD_RATE_4800;
      16'h0002: decoded_rate = BAUD_RATE_9600;
      16'h0003: decoded_rate = BAUD_RATE_19200;
      16'h0004: decoded_rate = BAUD_RATE_38400;
      16'h0005: decoded_rate = BAUD_RATE_57600;
      16'h0006: decoded_rate = BAUD_RATE_115200;
      default:  decoded_rate = 20'(state.baud * BAUD_OTHER_SCALE);
    endcase
    case (state.parity)
      16'h0001: decoded_parity = MBCFG_PAR_ODD;
      16'h0002: decoded_parity = MBCFG_PAR_EVEN;
      16'h0003: decoded_parity = MBCFG_PAR_ZERO;
      16'h0004: decoded_parity = MBCFG_PAR_ONE;
      default:  decoded_parity = MBCFG_PAR_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.reply_start = 1'b0;
    next_state.clear_all = 1'b0;
    next_state.rerror = 1'b0;

    // strap is caught one clocked cycle after reset release
    if (!state.strap_done) begin
      next_state.strap_done = 1'b1;
      next_state.restore_seen = restore_defaults_switch_in;
      if (restore_defaults_switch_in) begin
        next_state.baud = BAUD_DEFAULT;
        next_state.frame = FRAME_DEFAULT;
        next_state.parity = PARITY_DEFAULT;
        next_state.delay = DELAY_DEFAULT;
        next_state.protocol = PROTOCOL_DEFAULT;
        next_state.watchdog = WATCHDOG_DEFAULT;
        next_state.default_out = DEFOUT_DEFAULT;
        next_state.bus_address_set = 1'b0;
        next_state.clear_all = 1'b1;
      end
      next_state.settings_dirty = 1'b1;
    end

    // register writes, 16 bits wide except the station address, which keeps bits 7:0
    if (reg_write_in) begin
      next_state.settings_dirty = 1'b1;
      case (reg_index_in)
        REG_BAUD:         next_state.baud = reg_wdata_in;
        REG_FRAME:        next_state.frame = reg_wdata_in;
        REG_PARITY:       next_state.parity = reg_wdata_in;
        REG_REPLY_DELAY:  next_state.delay = reg_wdata_in;
        REG_PROTOCOL:     next_state.protocol = reg_wdata_in;
        REG_WATCHDOG:     next_state.watchdog = reg_wdata_in;
        REG_DEFAULT_OUT:  next_state.default_out = reg_wdata_in;
        REG_STATION_ADDR: begin
          next_state.bus_address = reg_wdata_in[7:0];
          next_state.bus_address_set = 1'b1;
        end
        default:          next_state.rerror = 1'b1;
      endcase
    end

    if (reg_read_in) begin
      case (reg_index_in)
        REG_IDENT:        next_state.rdata = IDENT_VALUE;
        REG_SWITCHES:     next_state.rdata = {10'h000, state.restore_seen, switch_address};
        REG_BAUD:         next_state.rdata = state.baud;
        REG_FRAME:        next_state.rdata = state.frame;
        REG_PARITY:       next_state.rdata = state.parity;
        REG_REPLY_DELAY:  next_state.rdata = state.delay;
        REG_PROTOCOL:     next_state.rdata = state.protocol;
        REG_WATCHDOG:     next_state.rdata = state.watchdog;
        REG_DEFAULT_OUT:  next_state.rdata = state.default_out;
        REG_STATION_ADDR: next_state.rdata = {8'h00, state.station};
        default: begin
          next_state.rdata = 16'h0000;
          next_state.rerror = 1'b1;
        end
      endcase
    end

    // switches give 0..31; larger addresses only through a write
    next_state.station = state.bus_address_set ? state.bus_address
                                               : {3'b000, switch_address};

    // reply hold-off and link indicator
    case (state.link)
      MBCFG_LINK_IDLE: begin
        if (frame_valid_own_in) begin
          next_state.delay_left = state.delay;
          next_state.link = MBCFG_LINK_DELAY;
        end
      end
      MBCFG_LINK_DELAY: begin
        if (state.delay_left == 16'h0000) begin
          next_state.reply_start = 1'b1;
          next_state.link_led = 1'b1;
          next_state.link = MBCFG_LINK_SEND;
        end else if (ms_tick) begin
          next_state.delay_left = state.delay_left - 16'h0001;
        end
      end
      MBCFG_LINK_SEND: begin
        if (reply_done_in) begin
          next_state.link_led = 1'b0;
          next_state.link = MBCFG_LINK_IDLE;
        end
      end
      default: next_state.link = MBCFG_LINK_IDLE;
    endcase

    // line settings only change while no reply is on the wire
    if (state.settings_dirty && state.link == MBCFG_LINK_IDLE) begin
      next_state.settings_dirty = reg_write_in;
      next_state.line_rate = decoded_rate;
      next_state.parity_mode = decoded_parity;
      next_state.two_stop = (state.frame[FRAME_STOP_LSB +: 8] == STOP_TWO);
      next_state.seven_data = (state.frame[FRAME_DATA_LSB +: 8] == DATA_SEVEN);
      next_state.ascii = state.protocol[0];
    end

    // watchdog: count whole milliseconds since the last restart
    if (wd_restart) begin
      next_state.wd_elapsed = 16'h0000;
      next_state.expired = 1'b0;
    end else if (state.watchdog == 16'h0000) begin
      next_state.wd_elapsed = 16'h0000;
      next_state.expired = 1'b0;
    end else if (ms_tick && !state.expired) begin
      next_state.wd_elapsed = state.wd_elapsed + 16'h0001;
      if (state.wd_elapsed + 16'h0001 >= state.watchdog) begin
        next_state.expired = 1'b1;
      end
    end

    // forced outputs hold the default pattern until a valid frame or a watchdog write restarts the watchdog
    if (!state.strap_done || state.expired) begin
      next_state.relays = state.default_out[OUT_WIDTH-1:0];
    end else begin
      next_state.relays = output_request_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register contents return to factory values on reset; the restore strap
  // additionally pulses clear_all for registers held outside the module
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state <= '0;
      state.baud <= BAUD_DEFAULT;
      state.frame <= FRAME_DEFAULT;
      state.parity <= PARITY_DEFAULT;
      state.delay <= DELAY_DEFAULT;
      state.protocol <= PROTOCOL_DEFAULT;
      state.watchdog <= WATCHDOG_DEFAULT;
      state.default_out <= DEFOUT_DEFAULT;
      state.link <= MBCFG_LINK_IDLE;
      state.line_rate <= BAUD_RATE_19200;
      state.parity_mode <= MBCFG_PAR_NONE;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_out = state.rdata;
  assign reg_error_out = state.rerror;
  assign line_rate_out = state.line_rate;
  assign parity_mode_out = state.parity_mode;
  assign two_stop_bits_out = state.two_stop;
  assign seven_data_bits_out = state.seven_data;
  assign ascii_framing_out = state.ascii;
  assign station_address_out = state.station;
  assign reply_start_out = state.reply_start;
  assign link_indicator_out = state.link_led;
  assign relay_outputs_out = state.relays;
  assign watchdog_expired_out = state.expired;
  assign clear_all_registers_out = state.clear_all;
endmodule
`default_nettype wire

// *** mbcfg_bank_properties.sv ***
// mbcfg_bank_properties: port-level timing checks for mbcfg_bank.
// assumes one clock, reset_in asynchronous active high; bound at the foot.
`timescale 1ns/100ps
`default_nettype none
module mbcfg_bank_properties #(
  parameter int unsigned OUT_WIDTH = 8,
  parameter int unsigned MS_DIVIDE = mbcfg_pkg::CYCLES_PER_MS
) (
  input wire logic                    clock_in,
  input wire logic                    reset_in,
  input wire logic                    reg_write_in,
  input wire logic                    reg_read_in,
  input wire logic [7:0]              reg_index_in,
  input wire logic [15:0]             reg_wdata_in,
  input wire logic                    frame_valid_own_in,
  input wire logic                    reply_done_in,
  input wire logic [OUT_WIDTH-1:0]    output_request_in,
  input wire logic [15:0]             reg_rdata_out,
  input wire logic                    reg_error_out,
  input wire logic                    reply_start_out,
  input wire logic                    link_indicator_out,
  input wire logic [OUT_WIDTH-1:0]    relay_outputs_out,
  input wire logic                    watchdog_expired_out,
  input wire logic                    clear_all_registers_out
);
  import mbcfg_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // shadow of the registers the checks depend on, kept from the strobes
  logic [15:0]          wd;
  logic [15:0]          dly;
  logic [OUT_WIDTH-1:0] dflt;
  logic [31:0]          cnt;
  logic [1:0]           up;
  logic                 bad_idx;
  logic                 wd_wr;
  assign bad_idx = !(reg_index_in inside {REG_IDENT, REG_SWITCHES, REG_BAUD, REG_FRAME,
                     REG_PARITY, REG_REPLY_DELAY, REG_PROTOCOL, REG_WATCHDOG,
                     REG_DEFAULT_OUT, REG_STATION_ADDR});
  assign wd_wr = reg_write_in && reg_index_in == REG_WATCHDOG;
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in || clear_all_registers_out) begin
      wd <= 16'h0000;
      dly <= 16'h0000;
      dflt <= '0;
    end else if (reg_write_in) begin
      if (reg_index_in == REG_WATCHDOG) wd <= reg_wdata_in;
      if (reg_index_in == REG_REPLY_DELAY) dly <= reg_wdata_in;
      if (reg_index_in == REG_DEFAULT_OUT) dflt <= reg_wdata_in[OUT_WIDTH-1:0];
    end
  end
  // cycles since the last watchdog restart; saturates so it never wraps
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cnt <= 32'h0;
      up <= 2'h0;
    end else begin
      cnt <= (frame_valid_own_in || wd_wr) ? 32'h0 : cnt + {31'h0, ~&cnt};
      up <= up + {1'b0, ~&up};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence s_taken;
    frame_valid_own_in && dly == 16'h0000 && !link_indicator_out && !reply_start_out
      && !$past(frame_valid_own_in) && up == 2'h3;
  endsequence
  sequence s_send;
    reply_start_out && link_indicator_out;
  endsequence
  a_prompt_reply_start: assert property (s_taken |-> ##[1:3] s_send)
    else $error("reply did not start promptly with zero delay");
  a_link_lights_start: assert property ($rose(link_indicator_out) |-> reply_start_out)
    else $error("link indicator rose without reply start");
  a_link_holds_up: assert property (link_indicator_out && !reply_done_in |=> link_indicator_out)
    else $error("link indicator dropped before reply done");
  a_link_drops_done: assert property (link_indicator_out && reply_done_in |=> !link_indicator_out)
    else $error("link indicator stayed after reply done");
  a_unmapped_error: assert property ((reg_read_in || reg_write_in) && bad_idx |=> reg_error_out)
    else $error("unmapped access gave no error");
  a_unmapped_zero: assert property (reg_read_in && bad_idx |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read returned nonzero");
  a_mapped_no_error: assert property ((reg_read_in || reg_write_in) && !bad_idx |=> !reg_error_out)
    else $error("mapped access flagged error");
  a_watchdog_off: assert property (wd == 16'h0000 |-> !watchdog_expired_out)
    else $error("watchdog expired while disabled");
  a_watchdog_not_early: assert property ($rose(watchdog_expired_out) |-> cnt + 32'h3 >= wd * MS_DIVIDE)
    else $error("watchdog expired before its timeout");
  a_relay_default_held: assert property (watchdog_expired_out
      && $past(watchdog_expired_out) |-> relay_outputs_out == dflt)
    else $error("relays not at default pattern after expiry");
  a_relay_follows_req: assert property (up == 2'h3 && !watchdog_expired_out
      && !$past(watchdog_expired_out) |-> relay_outputs_out == $past(output_request_in))
    else $error("relays not following request");
endmodule
bind mbcfg_bank mbcfg_bank_properties #(.OUT_WIDTH(OUT_WIDTH), .MS_DIVIDE(MS_DIVIDE)) props (.*);
`default_nettype wire

// *** mbcfg_master_model.sv ***
// mbcfg_master_model: far-side frame engine that finishes each reply.
// assumes reply_start_in is a one-cycle registered pulse of the bank.
`timescale 1ns/100ps
`default_nettype none
module mbcfg_master_model (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic slow_in,
  input wire logic reply_start_in,
  output var logic reply_done_out
);
  initial reply_done_out = 1'b0;
  // done only ever follows a start, so the order at the bank holds
  always @(negedge clock_in) begin
    if (reply_start_in === 1'b1 && !reset_in) begin
      repeat (slow_in ? 40 : 3) @(negedge clock_in);
      reply_done_out <= 1'b1;
      @(negedge clock_in);
      reply_done_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb.sv ***
// tb: register-access tests of mbcfg_bank with a reply-finishing partner.
// assumes MS_DIVIDE shortened to 10 cycles per millisecond.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mbcfg_pkg::*;
  localparam int MSD = 10;
  logic clock_in, reset_in, restore_defaults_switch_in, reg_write_in, reg_read_in;
  logic address_switch_weight_1_in, address_switch_weight_2_in, address_switch_weight_4_in;
  logic address_switch_weight_8_in, address_switch_weight_16_in;
  logic [7:0] reg_index_in, output_request_in, station_address_out, relay_outputs_out;
  logic [15:0] reg_wdata_in, reg_rdata_out, v;
  logic frame_valid_own_in, reply_done_in, reg_error_out, two_stop_bits_out, slow, seen_clear;
  logic seven_data_bits_out, ascii_framing_out, reply_start_out, link_indicator_out;
  logic watchdog_expired_out, clear_all_registers_out;
  mbcfg_parity_t parity_mode_out;
  int err_total, compares, cycles, n;
  logic [15:0] bcode [9] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'h7, 16'h3E8};
  logic [19:0] line_rate_out, brate [9] = '{BAUD_RATE_2400, BAUD_RATE_4800, BAUD_RATE_9600,
    BAUD_RATE_19200, BAUD_RATE_38400, BAUD_RATE_57600, BAUD_RATE_115200, 20'h00046, 20'h02710};
  logic [7:0] cidx [6] = '{REG_BAUD, REG_FRAME, REG_PARITY, REG_REPLY_DELAY, REG_PROTOCOL,
    REG_WATCHDOG};
  logic [15:0] cdef [6] = '{16'h0003, 16'h0801, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [4:0] sw, swp [4] = '{5'h00, 5'h16, 5'h1F, 5'h01};
  assign {address_switch_weight_16_in, address_switch_weight_8_in, address_switch_weight_4_in,
          address_switch_weight_2_in, address_switch_weight_1_in} = sw;
  mbcfg_bank #(.OUT_WIDTH(8), .MS_DIVIDE(MSD)) dut (.*);
  mbcfg_master_model partner (.clock_in(clock_in), .reset_in(reset_in), .slow_in(slow),
    .reply_start_in(reply_start_out), .reply_done_out(reply_done_in));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (reset_in === 1'b1) seen_clear <= 1'b0;
    else if (clear_all_registers_out === 1'b1) seen_clear <= 1'b1;
    cycles++;
    // well above the few hundred cycles the tests need
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [19:0] ex, input logic [19:0] got);
    compares++;
    if (got !== ex) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge clock_in);
  endtask
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    @(negedge clock_in);
    reg_write_in = 1'b1;
    reg_index_in = i;
    reg_wdata_in = d;
    @(negedge clock_in);
    reg_write_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [15:0] d);
    @(negedge clock_in);
    reg_read_in = 1'b1;
    reg_index_in = i;
    @(negedge clock_in);
    reg_read_in = 1'b0;
    d = reg_rdata_out;
  endtask
  task automatic reply(output int k);
    @(negedge clock_in);
    frame_valid_own_in = 1'b1;
    @(negedge clock_in);
    frame_valid_own_in = 1'b0;
    k = 1;
    while (reply_start_out !== 1'b1 && k < 200) begin
      @(negedge clock_in);
      k++;
    end
  endtask
  task automatic link_low();
    for (int k = 0; k < 100 && link_indicator_out !== 1'b0; k++) @(negedge clock_in);
    idle(4);
  endtask
  task automatic rst(input logic strap);
    reset_in = 1'b1;
    restore_defaults_switch_in = strap;
    idle(5);
    reset_in = 1'b0;
    idle(3);
    restore_defaults_switch_in = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reg_write_in, reg_read_in, frame_valid_own_in, slow} = '0;
    {reg_index_in, reg_wdata_in, sw, restore_defaults_switch_in} = '0;
    output_request_in = 8'h3C;
    rst(1'b0);
    chk("no clear pulse", 20'h0, 20'(seen_clear));
    for (int k = 0; k < 6; k++) begin
      rd(cidx[k], v);
      chk("reset value", {4'h0, cdef[k]}, {4'h0, v});
    end
    chk("line rate", BAUD_RATE_19200, line_rate_out);
    chk("stop and data", 20'h0, {two_stop_bits_out, seven_data_bits_out, ascii_framing_out});
    rd(8'h07, v);
    chk("unmapped read", 20'h0, {4'h0, v});
    wr(8'h0E, 16'hFFFF);
    $display("test defaults done");
    for (int k = 0; k < 9; k++) begin
      wr(REG_BAUD, bcode[k]);
      idle(4);
      chk("line rate", brate[k], line_rate_out);
    end
    for (int k = 0; k < 5; k++) begin
      wr(REG_PARITY, 16'(k));
      idle(4);
      chk("parity", 20'(k), 20'(parity_mode_out));
    end
    wr(REG_FRAME, 16'h0702);
    wr(REG_PROTOCOL, 16'h0001);
    idle(4);
    chk("two stop", 20'h1, 20'(two_stop_bits_out));
    chk("seven data", 20'h1, 20'(seven_data_bits_out));
    chk("ascii", 20'h1, 20'(ascii_framing_out));
    wr(REG_FRAME, 16'h0801);
    wr(REG_PROTOCOL, 16'h0000);
    idle(4);
    chk("frame back", 20'h0, {two_stop_bits_out, seven_data_bits_out, ascii_framing_out});
    $display("test line settings done");
    for (int k = 0; k < 4; k++) begin
      sw = swp[k];
      idle(3);
      chk("station", {15'h0, swp[k]}, 20'(station_address_out));
      rd(REG_SWITCHES, v);
      chk("switch reg", {15'h0, swp[k]}, {15'h0, v[4:0]});
    end
    wr(REG_STATION_ADDR, 16'h00C8);
    sw = 5'h03;
    idle(3);
    chk("bus address", 20'h000C8, 20'(station_address_out));
    $display("test address done");
    reply(n);
    chk("prompt reply", 20'h1, 20'(n <= 3));
    chk("link on", 20'h1, 20'(link_indicator_out));
    link_low();
    chk("link off", 20'h0, 20'(link_indicator_out));
    wr(REG_REPLY_DELAY, 16'h0002);
    slow = 1'b1;
    reply(n);
    chk("delayed reply", 20'h1, 20'(n > MSD && n <= 2 * MSD + 4));
    wr(REG_BAUD, 16'h0000);
    idle(3);
    chk("rate held in reply", 20'h02710, line_rate_out);
    link_low();
    chk("rate after reply", BAUD_RATE_2400, line_rate_out);
    slow = 1'b0;
    wr(REG_REPLY_DELAY, 16'h0000);
    $display("test reply done");
    chk("watchdog off", 20'h0, 20'(watchdog_expired_out));
    wr(REG_DEFAULT_OUT, 16'h00A5);
    wr(REG_WATCHDOG, 16'h0003);
    for (int k = 0; k < 4; k++) begin
      output_request_in = 8'h30 + 8'(k);
      idle(20);
      reply(n);
      chk("watchdog restarted", 20'h0, 20'(watchdog_expired_out));
    end
    chk("relays follow", 20'h00033, 20'(relay_outputs_out));
    idle(45);
    chk("watchdog expired", 20'h1, 20'(watchdog_expired_out));
    chk("default relays", 20'h000A5, 20'(relay_outputs_out));
    $display("test watchdog done");
    wr(REG_BAUD, 16'h0005);
    rst(1'b1);
    chk("clear pulse", 20'h1, 20'(seen_clear));
    rd(REG_BAUD, v);
    chk("restored baud", 20'h00003, {4'h0, v});
    rd(REG_DEFAULT_OUT, v);
    chk("cleared default", 20'h0, {4'h0, v});
    rd(REG_WATCHDOG, v);
    chk("cleared watchdog", 20'h0, {4'h0, v});
    $display("test restore done");
    summarize();
  end
endmodule
`default_nettype wire
